// [rtl/safety_start_map.svh]
// constants for the safety switch start logic
`ifndef SAFETY_START_MAP_SVH
`define SAFETY_START_MAP_SVH
`define CLK_PERIOD_PS       32'd5000
`define START_MIN_MS        32'd100
`define START_MAX_MS        32'd2000
`define START_MIN_CYC       (((`START_MIN_MS) * 64'd1000000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define START_MAX_CYC       (((`START_MAX_MS) * 64'd1000000000) / `CLK_PERIOD_PS)
`define PULSE_PERIOD_CYC    32'd2000
`define PULSE_WIDTH_CYC     32'd40
`define DETECT_WIN_CYC      32'd6000
`define PULSE_SEEN_MIN      3'h2
`endif

// [rtl/safety_start_pkg.sv]
// types for the safety switch start logic
package safety_start_pkg;
	typedef enum logic [1:0] {MODE_UNKNOWN, MODE_AUTO, MODE_MANUAL} start_mode_t;
	typedef enum logic [1:0] {ST_IDLE, ST_PRESSED, ST_ARMED, ST_ON} run_state_t;
endpackage : safety_start_pkg

// [rtl/test_pulse_gen.sv]
// periodic test pulse generator for the safety outputs
`timescale 1ns/1ps
`include "safety_start_map.svh"
module test_pulse_gen (
	input  wire logic core_clk,   // system clock
	input  wire logic rst_n,      // async reset, active low
	output logic      pulse_a,    // test pulse slot of output a
	output logic      pulse_b     // test pulse slot of output b, offset by half a period
);
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic        pa_next;
	logic        pb_next;

	// free-running period counter; b slot lies half a period later so the patterns differ
	assign cnt_next = (cnt_reg == `PULSE_PERIOD_CYC - 32'd1) ? 32'h0 : cnt_reg + 32'h1;
	assign pa_next  = (cnt_next < `PULSE_WIDTH_CYC);
	assign pb_next  = (cnt_next >= (`PULSE_PERIOD_CYC >> 1))
		&& (cnt_next < (`PULSE_PERIOD_CYC >> 1) + `PULSE_WIDTH_CYC);

	// registered outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 32'h0;
			pulse_a <= 1'b0;
			pulse_b <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			pulse_a <= pa_next;
			pulse_b <= pb_next;
		end
	end
endmodule : test_pulse_gen

// [rtl/safety_start_ctrl.sv]
// start/reset control of the non-contact safety switch
`timescale 1ns/1ps
`include "safety_start_map.svh"
// Overview of operation
// RL1: autostart turns outputs on once a valid actuator is present.
// RL2: manual mode needs valid actuator plus a press and release of reset.
// RL3: test pulses of output a seen on start input select autostart.
// RL4: no pulses seen means manual mode; start level change is the command.
// RL5: manual start fires on the falling edge of the high start level.
// RL6: start high time must lie between 100 ms and 2 s.
// RL7: for autostart the start input is wired to output a.
// RL8: in a chain, reset centrally and run switches in autostart.
// RL9: outputs stay off while safety inputs are not both energised.
// RL10: outputs on only if actuator valid and started; diag on otherwise.
// RL11: outputs carry test pulses when on and during device start.
module safety_start_ctrl (
	input  wire logic core_clk,         // system clock, 200 MHz
	input  wire logic rst_n,            // async reset, active low
	input  wire logic actuator_valid,   // actuator in response area with permissible coding
	input  wire logic safe_in_a,        // safety input a energised
	input  wire logic safe_in_b,        // safety input b energised
	input  wire logic start_in,         // start/reset input level
	output logic      safe_out_a,       // safety output a
	output logic      safe_out_b,       // safety output b
	output logic      diag_signal_out,  // diagnostic output
	output logic      auto_mode,        // startup behaviour is autostart
	output logic      start_fault       // last start pulse was out of its time window
);
	logic                         pulse_a;
	logic                         pulse_b;
	logic [31:0]                  win_reg;
	logic [2:0]                   seen_reg;
	logic                         start_d_reg;
	logic                         out_a_d_reg;
	logic [31:0]                  hi_cnt_reg;
	safety_start_pkg::start_mode_t mode_reg;
	safety_start_pkg::run_state_t  state_reg;
	safety_start_pkg::run_state_t  state_next;

	test_pulse_gen u_pulses (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.pulse_a  (pulse_a),
		.pulse_b  (pulse_b)
	);

	// true when the start input falls in the same cycle as the output ends its pulse
	function automatic logic pulse_echo(input logic out_prev, input logic out_now,
		input logic in_prev, input logic in_now);
		pulse_echo = out_prev && !out_now && in_prev && !in_now;
	endfunction : pulse_echo

	wire logic chain_ok    = safe_in_a && safe_in_b;
	// input decodes; a held level is not a press, only its rising edge is
	wire logic start_fall  = start_d_reg && !start_in;
	wire logic start_rise  = start_in && !start_d_reg;
	wire logic win_end     = (win_reg == `DETECT_WIN_CYC - 32'd1);
	// a bridged input falls in the very cycle output a ends its pulse; a button cannot
	// repeat that coincidence every period, which is why two echoes are required
	wire logic echo_a      = pulse_echo(out_a_d_reg, safe_out_a, start_d_reg, start_in);
	wire logic detecting   = (mode_reg == safety_start_pkg::MODE_UNKNOWN);
	// RL6: window check
	wire logic len_ok      = (hi_cnt_reg >= 32'(`START_MIN_CYC))
		&& (hi_cnt_reg <= 32'(`START_MAX_CYC));
	wire logic permit      = actuator_valid && chain_ok;
	wire logic outputs_on  = (state_reg == safety_start_pkg::ST_ON);

	// RL3: count echoes of output a while detecting
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			win_reg  <= 32'h0;
			seen_reg <= 3'h0;
		end else if (detecting) begin
			win_reg  <= win_reg + 32'h1;
			if (echo_a && seen_reg != 3'h7)
				seen_reg <= seen_reg + 3'h1;
		end
	end

	// RL3: decide mode at the end of the detection window
	// RL4: no echo seen means manual monitored start
	// the mode then stays fixed until reset, so rewiring at run time changes nothing
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= safety_start_pkg::MODE_UNKNOWN;
		end else if (detecting && win_end) begin
			mode_reg <= (seen_reg >= `PULSE_SEEN_MIN) ? safety_start_pkg::MODE_AUTO
				: safety_start_pkg::MODE_MANUAL;
		end
	end

	// RL6: measure the high time of the start input, saturating
	// saturation keeps a stuck button from wrapping back into the accepted window
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_d_reg <= 1'b0;
			hi_cnt_reg  <= 32'h0;
		end else begin
			start_d_reg <= start_in;
			if (!start_in)
				hi_cnt_reg <= 32'h0;
			else if (hi_cnt_reg != 32'hFFFFFFFF)
				hi_cnt_reg <= hi_cnt_reg + 32'h1;
		end
	end

	// run state: idle until start condition, on while permitted
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			safety_start_pkg::ST_IDLE: begin
				// RL1: autostart needs only a valid actuator and both safety inputs energised
				if (mode_reg == safety_start_pkg::MODE_AUTO && permit)
					state_next = safety_start_pkg::ST_ON;
				// RL2: manual path opens only on a press that begins with actuator present
				else if (mode_reg == safety_start_pkg::MODE_MANUAL && permit && start_rise)
					state_next = safety_start_pkg::ST_PRESSED;
				// a press already held when the actuator arrives must be released first
				else if (mode_reg == safety_start_pkg::MODE_MANUAL && permit && start_in)
					state_next = safety_start_pkg::ST_ARMED;
			end
			safety_start_pkg::ST_PRESSED: begin
				// RL5: release edge with a good length starts
				if (!permit)
					state_next = safety_start_pkg::ST_IDLE;
				else if (start_fall)
					state_next = len_ok ? safety_start_pkg::ST_ON : safety_start_pkg::ST_IDLE;
			end
			safety_start_pkg::ST_ARMED: begin
				// RL2: held press is void; wait for its release, never start from it
				if (!start_in || !permit)
					state_next = safety_start_pkg::ST_IDLE;
			end
			safety_start_pkg::ST_ON: begin
				// RL9: loss of chain or actuator drops the outputs
				if (!permit)
					state_next = safety_start_pkg::ST_IDLE;
			end
		endcase
	end

	// state register and fault flag
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= safety_start_pkg::ST_IDLE;
			start_fault <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == safety_start_pkg::ST_PRESSED && start_fall)
				start_fault <= !len_ok;
		end
	end

	// RL10: outputs and diag from state; RL11: test pulses while on and while detecting
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			safe_out_a      <= 1'b0;
			safe_out_b      <= 1'b0;
			diag_signal_out <= 1'b1;
			auto_mode       <= 1'b0;
			out_a_d_reg     <= 1'b0;
		end else begin
			// a pulse drives the line low when on and high briefly while detecting
			safe_out_a      <= (state_next == safety_start_pkg::ST_ON) ? !pulse_a
				: (detecting && pulse_a);
			safe_out_b      <= (state_next == safety_start_pkg::ST_ON) ? !pulse_b
				: (detecting && pulse_b);
			diag_signal_out <= (state_next != safety_start_pkg::ST_ON);
			auto_mode       <= (mode_reg == safety_start_pkg::MODE_AUTO);
			// delayed copy of output a, used to find the end of each pulse for the echo
			out_a_d_reg     <= safe_out_a;
		end
	end

	// checks: each guards one rule of the logic above; reset masks them all
	a_chain_gates_out: assert property (@(posedge core_clk) disable iff (!rst_n) // RL9
		!chain_ok |=> !outputs_on) else $error("outputs on with chain off");
	a_actuator_gates: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
		!actuator_valid |=> !outputs_on) else $error("outputs on without actuator");
	a_auto_starts: assert property (@(posedge core_clk) disable iff (!rst_n) // RL1
		(mode_reg == safety_start_pkg::MODE_AUTO && permit
		&& state_reg == safety_start_pkg::ST_IDLE)
		|=> outputs_on) else $error("autostart did not switch on");
	a_manual_edge: assert property (@(posedge core_clk) disable iff (!rst_n) // RL5
		(mode_reg == safety_start_pkg::MODE_MANUAL && $rose(outputs_on))
		|-> $past(start_fall)) else $error("manual start without release");
	a_manual_press: assert property (@(posedge core_clk) disable iff (!rst_n) // RL2
		(mode_reg == safety_start_pkg::MODE_MANUAL && $rose(outputs_on))
		|-> $past(state_reg) == safety_start_pkg::ST_PRESSED) else $error("no press seen");
	a_held_refused: assert property (@(posedge core_clk) disable iff (!rst_n) // RL2
		(state_reg == safety_start_pkg::ST_IDLE && start_in && start_d_reg)
		|=> state_reg != safety_start_pkg::ST_PRESSED) else $error("held press accepted");
	a_len_window: assert property (@(posedge core_clk) disable iff (!rst_n) // RL6
		(state_reg == safety_start_pkg::ST_PRESSED && start_fall && !len_ok)
		|=> !outputs_on && start_fault) else $error("bad start length accepted");
	a_good_release: assert property (@(posedge core_clk) disable iff (!rst_n) // RL5
		(state_reg == safety_start_pkg::ST_PRESSED && start_fall && len_ok && permit)
		|=> outputs_on && !start_fault) else $error("good release did not start");
	a_mode_select: assert property (@(posedge core_clk) disable iff (!rst_n) // RL3
		(detecting && win_end && seen_reg >= `PULSE_SEEN_MIN)
		|=> mode_reg == safety_start_pkg::MODE_AUTO) else $error("autostart not chosen");
	a_manual_select: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
		(detecting && win_end && seen_reg == 3'h0)
		|=> mode_reg == safety_start_pkg::MODE_MANUAL) else $error("manual not chosen");
	a_mode_fixed: assert property (@(posedge core_clk) disable iff (!rst_n) // RL3
		!detecting |=> $stable(mode_reg)) else $error("mode changed after decision");
	a_quiet_deciding: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
		detecting |=> !outputs_on) else $error("outputs on before mode decided");
	a_diag_when_off: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
		!permit |=> diag_signal_out) else $error("diag off without actuator or chain");
	a_pulse_when_on: assert property (@(posedge core_clk) disable iff (!rst_n) // RL11
		(outputs_on && $past(outputs_on) && $past(pulse_a)) |-> !safe_out_a)
		else $error("no test pulse on output a");
	a_pulse_b_when_on: assert property (@(posedge core_clk) disable iff (!rst_n) // RL11
		(outputs_on && $past(outputs_on) && $past(pulse_b)) |-> !safe_out_b)
		else $error("no test pulse on output b");
	// covers for the main paths
	c_auto_on: cover property (@(posedge core_clk) disable iff (!rst_n)
		auto_mode && $rose(outputs_on));
	c_manual_on: cover property (@(posedge core_clk) disable iff (!rst_n)
		mode_reg == safety_start_pkg::MODE_MANUAL && $rose(outputs_on));
	c_bad_start: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(start_fault));
	c_held_press: cover property (@(posedge core_clk) disable iff (!rst_n)
		state_reg == safety_start_pkg::ST_ARMED);
	c_drop_out: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(outputs_on));
endmodule : safety_start_ctrl

// [test/start_source.sv]
// far side model: reset button or bridge to output a, plus preceding switch
`timescale 1ns/1ps
module start_source (
	input  wire logic wire_auto,  // start input bridged to output a
	input  wire logic button,     // reset button pressed
	input  wire logic chain_on,   // preceding switch outputs on
	input  wire logic safe_out_a, // output a of the switch
	output logic      start_in,   // start input level
	output logic      safe_in_a,  // safety input a
	output logic      safe_in_b   // safety input b
);
	// bridge to output a; a released button reads low, as through a pull-down
	assign start_in  = wire_auto ? safe_out_a : button;
	// preceding switch runs in autostart, its reset is done centrally upstream
	assign safe_in_a = chain_on;
	assign safe_in_b = chain_on;
endmodule : start_source

// [test/testbench.sv]
// self-checking bench for the safety switch start logic
`timescale 1ns/1ps
`include "safety_start_map.svh"
module testbench;
	logic core_clk       = 1'b0;
	logic rst_n          = 1'b0;
	logic actuator_valid = 1'b0;
	logic wire_auto      = 1'b0;
	logic button         = 1'b0;
	logic chain_on       = 1'b0;
	logic start_in, safe_in_a, safe_in_b;
	logic safe_out_a, safe_out_b, diag_signal_out, auto_mode, start_fault;
	int   n_errors       = 0;
	int   total_checks   = 0;

	// 200 MHz clock
	always #2.5 core_clk = ~core_clk;

	safety_start_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n),
		.actuator_valid(actuator_valid), .safe_in_a(safe_in_a), .safe_in_b(safe_in_b),
		.start_in(start_in), .safe_out_a(safe_out_a), .safe_out_b(safe_out_b),
		.diag_signal_out(diag_signal_out), .auto_mode(auto_mode), .start_fault(start_fault));

	start_source far_side (.wire_auto(wire_auto), .button(button), .chain_on(chain_on),
		.safe_out_a(safe_out_a), .start_in(start_in), .safe_in_a(safe_in_a),
		.safe_in_b(safe_in_b));

	// compare one value and report a mismatch at once
	task automatic check(input string what, input logic seen, input logic expected);
		total_checks++;
		if (seen !== expected) begin
			n_errors++;
			$display("CHECK FAILED %s expected %b seen %b", what, expected, seen);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	// reset held 8 cycles with the start input wired as asked
	task automatic do_reset(input logic autow);
		@(posedge core_clk);
		rst_n     <= 1'b0;
		wire_auto <= autow;
		repeat (8) @(posedge core_clk);
		rst_n     <= 1'b1;
	endtask : do_reset

	// bridged start input: echoes choose autostart, then outputs follow actuator and chain
	task automatic test_auto();
		int i;
		int n_low_a;
		int n_low_b;
		do_reset(1'b1);
		chain_on <= 1'b1;
		// poll between edges so the mode flag is read when settled
		for (i = 0; i < 7000 && auto_mode !== 1'b1; i++) begin
			@(negedge core_clk);
		end
		if (auto_mode !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED auto_mode expected 1 seen timeout");
			return;
		end
		check("auto_mode", auto_mode, 1'b1);
		check("diag idle", diag_signal_out, 1'b1);
		check("out_a idle", safe_out_a, 1'b0);
		@(posedge core_clk);
		actuator_valid <= 1'b1;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		check("diag on", diag_signal_out, 1'b0);
		// over one full period each output is low for exactly one test pulse
		n_low_a = 0;
		n_low_b = 0;
		repeat (`PULSE_PERIOD_CYC) begin
			@(negedge core_clk);
			if (safe_out_a !== 1'b1)
				n_low_a++;
			if (safe_out_b !== 1'b1)
				n_low_b++;
		end
		check("out_a on with one pulse", n_low_a == `PULSE_WIDTH_CYC, 1'b1);
		check("out_b on with one pulse", n_low_b == `PULSE_WIDTH_CYC, 1'b1);
		// dropping the chain must switch off even with actuator present
		@(posedge core_clk);
		chain_on <= 1'b0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		check("out_a chain off", safe_out_a, 1'b0);
		check("out_b chain off", safe_out_b, 1'b0);
		check("diag chain off", diag_signal_out, 1'b1);
		// chain back: autostart switches on again without any operator action
		@(posedge core_clk);
		chain_on <= 1'b1;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		check("diag chain back", diag_signal_out, 1'b0);
		// actuator leaves the response area: outputs off, diag on
		@(posedge core_clk);
		actuator_valid <= 1'b0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		check("out_a actuator gone", safe_out_a, 1'b0);
		check("diag actuator gone", diag_signal_out, 1'b1);
		$display("test_auto done");
	endtask : test_auto

	// no echo: manual mode; a held press and a too short press are both refused
	task automatic test_manual();
		do_reset(1'b0);
		chain_on <= 1'b1;
		repeat (6100) @(posedge core_clk);
		@(negedge core_clk);
		check("auto_mode manual", auto_mode, 1'b0);
		check("out_a no start", safe_out_a, 1'b0);
		check("diag no start", diag_signal_out, 1'b1);
		check("start_fault reset", start_fault, 1'b0);
		// press before the actuator arrives, release after: no start, no timing verdict
		@(posedge core_clk);
		button <= 1'b1;
		repeat (10) @(posedge core_clk);
		actuator_valid <= 1'b1;
		repeat (1000) @(posedge core_clk);
		button <= 1'b0;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		check("start_fault held press", start_fault, 1'b0);
		check("out_a held press", safe_out_a, 1'b0);
		// fresh press of 1000 cycles lies far below the minimum high time
		@(posedge core_clk);
		button <= 1'b1;
		repeat (1000) @(posedge core_clk);
		button <= 1'b0;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		check("start_fault short", start_fault, 1'b1);
		check("out_a short press", safe_out_a, 1'b0);
		check("diag short press", diag_signal_out, 1'b1);
		$display("test_manual done");
	endtask : test_manual

	initial begin
		test_auto();
		test_manual();
		summarize();
	end
endmodule : testbench
